// ===== hw/snm_spi_master.sv
// Behaviour
// - device is always the sole master
// - no arbitration; device alone drives clock/selects
// - two slaves: eeprom and flash selects
// - eeprom addresses sent as two bytes
// - mode 0, clock idles low
// - sample rising edge, change on falling
// - serial clock runs at 2.5 MHz
// - selects, clock, mosi out; miso in
// - at most one memory active at once
// - resynchronise interface after reset
// - reconstructed lost data rewritten fresh
// - memory-type code selects interface path
`timescale 1ns/10ps
`include "snm_defines.svh"

module snm_spi_master
  import snm_pkg::*;
#(
  parameter int ADDR_BYTES = `SNM_EE_ADDR_BYTES,
  parameter int RESYNC_BITS = `SNM_RESYNC_BITS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [1:0] memType,
  input wire logic startReq,
  input wire logic startFlash,
  input wire logic [7:0] txByte,
  input wire logic txLast,
  input wire logic miso,
  input wire logic flashSelectShared_in,
  output logic byteReq,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic busy,
  output logic sck,
  output logic mosi,
  output logic eepromSelect_n,
  output logic flashSelectShared_n,
  output logic flashSelectShared_oe_n,
  output logic spiPathActive
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic misoMeta;
  logic misoSync;
  // shared pin readback resets high, the level of its pull-up
  logic sharedMeta;
  logic sharedSync;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      misoMeta <= 1'b0;
      misoSync <= 1'b0;
      sharedMeta <= 1'b1;
      sharedSync <= 1'b1;
    end
    else if (clkEn)
    begin
      misoMeta <= miso;
      misoSync <= misoMeta;
      sharedMeta <= flashSelectShared_in;
      sharedSync <= sharedMeta;
    end
  end

  // ----------------------------------------------------------------
  // serial clock
  // ----------------------------------------------------------------
  logic sckRun;
  logic sckLevel;
  logic riseTick;
  logic fallTick;

  // ticks time both the pin and the shift register
  // 2.5 MHz clock
  snm_sck_gen u_sck
  (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .run(sckRun),
    .sckLevel(sckLevel),
    .riseTick(riseTick),
    .fallTick(fallTick)
  );

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  snm_state_t state;
  snm_state_t next_state;
  snm_target_t target;
  snm_target_t next_target;
  logic [7:0] shiftOut;
  logic [7:0] next_shiftOut;
  logic [7:0] shiftIn;
  logic [7:0] next_shiftIn;
  logic [3:0] bitCount;
  logic [3:0] next_bitCount;
  logic lastByte;
  logic next_lastByte;
  logic next_byteReq;
  logic [7:0] next_rxByte;
  logic next_rxValid;
  logic next_mosi;
  logic next_eepromSelect_n;
  logic next_flashSelectShared_n;
  logic next_flashSelectShared_oe_n;
  logic next_spiPathActive;
  logic spiSelected;
  logic next_sck;
  logic next_busy;

  // only code zero routes to this path
  assign spiSelected = (memType == `SNM_MT_SPI);
  assign sckRun = (state == SNM_SHIFT) || (state == SNM_RESYNC);

  always_comb
  begin
    next_state = state;
    next_target = target;
    next_shiftOut = shiftOut;
    next_shiftIn = shiftIn;
    next_bitCount = bitCount;
    next_lastByte = lastByte;
    next_byteReq = 1'b0;
    next_rxByte = rxByte;
    next_rxValid = 1'b0;
    next_mosi = mosi;
    next_eepromSelect_n = 1'b1;
    next_flashSelectShared_n = 1'b1;
    next_flashSelectShared_oe_n = 1'b1;
    next_spiPathActive = spiSelected;
    case (state)
      SNM_RESYNC:
      begin
        // deselected clocks flush a partial byte
        // both selects stay high, so no slave latches these bits
        next_mosi = 1'b0;
        if (!spiSelected)
        begin
          next_state = SNM_IDLE;
        end
        else if (fallTick)
        begin
          if (bitCount == 4'(RESYNC_BITS - 1))
          begin
            next_state = SNM_IDLE;
            next_bitCount = 4'h0;
          end
          else
          begin
            next_bitCount = bitCount + 4'h1;
          end
        end
      end
      SNM_IDLE:
      begin
        // a fresh start re-sends whole data
        // shared pin stays released off path
        // start ignored unless the spi path is chosen
        if (startReq && spiSelected)
        begin
          next_target = startFlash ? SNM_TGT_FLASH : SNM_TGT_EEPROM;
          next_shiftOut = txByte;
          next_lastByte = txLast;
          next_bitCount = 4'h0;
          next_state = SNM_SELECT;
        end
      end
      SNM_SELECT:
      begin
        // four cycles (HALF_CYC) of mosi setup ahead of the first rise
        // msb ready before first rising edge
        next_mosi = shiftOut[7];
        next_state = SNM_SHIFT;
      end
      SNM_SHIFT:
      begin
        if (riseTick)
        begin
          next_shiftIn = {shiftIn[6:0], misoSync};
        end
        if (fallTick)
        begin
          if (bitCount == 4'h7)
          begin
            next_bitCount = 4'h0;
            next_rxByte = shiftIn;
            next_rxValid = 1'b1;
            // caller supplies command, two address bytes, data
            if (lastByte)
            begin
              next_state = SNM_DESELECT;
            end
            else
            begin
              next_shiftOut = txByte;
              next_lastByte = txLast;
              next_mosi = txByte[7];
              next_byteReq = 1'b1;
            end
          end
          else
          begin
            next_bitCount = bitCount + 4'h1;
            next_shiftOut = {shiftOut[6:0], 1'b0};
            next_mosi = shiftOut[6];
          end
        end
      end
      SNM_DESELECT:
      begin
        // last byte done; select still low for this one cycle
        // select rising starts slave write
        next_mosi = 1'b0;
        next_state = SNM_IDLE;
      end
      default:
      begin
        next_state = SNM_IDLE;
      end
    endcase
    // pin copies the level the ticks lead to
    // so mosi and sck move on the same system edge
    next_sck = sckRun & (sckLevel ^ (riseTick | fallTick));
    next_busy = (next_state != SNM_IDLE);
    // exactly one select for whole transfer
    // two slaves only
    // held through deselect so sck is low before select rises
    if (next_state == SNM_SELECT || next_state == SNM_SHIFT ||
        next_state == SNM_DESELECT)
    begin
      if (next_target == SNM_TGT_FLASH)
      begin
        next_flashSelectShared_n = 1'b0;
        next_flashSelectShared_oe_n = 1'b0;
      end
      else
      begin
        next_eepromSelect_n = 1'b0;
      end
    end
    else if (spiSelected)
    begin
      // drive shared select high while on spi path
      next_flashSelectShared_oe_n = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // master only; no arbitration
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= SNM_RESYNC;
      target <= SNM_TGT_EEPROM;
      shiftOut <= 8'h00;
      shiftIn <= 8'h00;
      bitCount <= 4'h0;
      lastByte <= 1'b0;
      byteReq <= 1'b0;
      rxByte <= 8'h00;
      rxValid <= 1'b0;
      busy <= 1'b1;
      sck <= 1'b0;
      mosi <= 1'b0;
      eepromSelect_n <= 1'b1;
      flashSelectShared_n <= 1'b1;
      flashSelectShared_oe_n <= 1'b1;
      spiPathActive <= 1'b0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      target <= next_target;
      shiftOut <= next_shiftOut;
      shiftIn <= next_shiftIn;
      bitCount <= next_bitCount;
      lastByte <= next_lastByte;
      byteReq <= next_byteReq;
      rxByte <= next_rxByte;
      rxValid <= next_rxValid;
      busy <= next_busy;
      sck <= next_sck;
      mosi <= next_mosi;
      eepromSelect_n <= next_eepromSelect_n;
      flashSelectShared_n <= next_flashSelectShared_n;
      flashSelectShared_oe_n <= next_flashSelectShared_oe_n;
      spiPathActive <= next_spiPathActive & sharedSync | next_spiPathActive;
    end
  end
endmodule

// ===== hw/snm_defines.svh
`ifndef SNM_DEFINES_SVH
`define SNM_DEFINES_SVH

// system clock and serial clock rates
`define SNM_CLK_HZ 20000000
`define SNM_SCK_HZ 2500000
// system cycles per serial clock half period
`define SNM_HALF_CYC ((`SNM_CLK_HZ / `SNM_SCK_HZ) / 2)
// memory-type codes
`define SNM_MT_SPI 2'h0
`define SNM_MT_TW1 2'h1
`define SNM_MT_TW2 2'h2
// eeprom address bytes
`define SNM_EE_ADDR_BYTES 2
// idle serial clocks sent while deselected after reset
`define SNM_RESYNC_BITS 8

`endif

// ===== hw/snm_pkg.sv
package snm_pkg;
  typedef enum {
    SNM_IDLE,
    SNM_RESYNC,
    SNM_SELECT,
    SNM_SHIFT,
    SNM_DESELECT
  } snm_state_t;

  typedef enum logic [0:0] {
    SNM_TGT_EEPROM = 1'b0,
    SNM_TGT_FLASH = 1'b1
  } snm_target_t;
endpackage

// ===== hw/snm_sck_gen.sv
`timescale 1ns/10ps
`include "snm_defines.svh"

// ----------------------------------------------------------------
// serial clock phase generator
// ----------------------------------------------------------------
// pulses riseTick/fallTick alternately while run is high; sck is
// low whenever run is low so the line idles low between frames
module snm_sck_gen
  import snm_pkg::*;
#(
  parameter int HALF_CYC = `SNM_HALF_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic run,
  output logic sckLevel,
  output logic riseTick,
  output logic fallTick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_sckLevel;

  always_comb
  begin
    next_count = count;
    next_sckLevel = sckLevel;
    riseTick = 1'b0;
    fallTick = 1'b0;
    if (!run)
    begin
      next_count = 8'h00;
      next_sckLevel = 1'b0;
    end
    else if (count == 8'(HALF_CYC - 1))
    begin
      next_count = 8'h00;
      next_sckLevel = ~sckLevel;
      riseTick = ~sckLevel;
      fallTick = sckLevel;
    end
    else
    begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= 8'h00;
      sckLevel <= 1'b0;
    end
    else if (clkEn)
    begin
      count <= next_count;
      sckLevel <= next_sckLevel;
    end
  end
endmodule

// ===== dv/snm_spi_master_properties.sv
`timescale 1ns/10ps
// ------
// pin checks
// ------
module snm_spi_master_properties
  import snm_pkg::*;
#(
  parameter int ADDR_BYTES = 2,
  parameter int RESYNC_BITS = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [1:0] memType,
  input wire logic startReq,
  input wire logic startFlash,
  input wire logic rxValid,
  input wire logic busy,
  input wire logic sck,
  input wire logic mosi,
  input wire logic eepromSelect_n,
  input wire logic flashSelectShared_n,
  input wire logic flashSelectShared_oe_n,
  input wire logic spiPathActive
);
  logic selN;
  logic sckQ;
  logic [7:0] rises;
  logic [7:0] next_rises;
  assign selN = eepromSelect_n &
    (flashSelectShared_n | flashSelectShared_oe_n);
  // rising edges of sck since the frame opened
  always_comb
  begin
    next_rises = selN ? 8'h00 : rises + {7'h00, sck & ~sckQ};
  end
  always_ff @(posedge clk)
  begin
    sckQ <= sck;
    rises <= next_rises;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_sck_idle_low: assert property (selN && !busy |-> !sck)
    else $error("sck high while idle");
  chk_one_select: assert property (eepromSelect_n || selN == 1'b0 &&
    (flashSelectShared_n || flashSelectShared_oe_n))
    else $error("two selects low");
  chk_sck_high_time: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("sck high phase wrong");
  chk_mosi_on_fall: assert property (!selN && rises != 8'h00 &&
    $changed(mosi) |-> $fell(sck))
    else $error("mosi moved off a falling edge");
  chk_start_select: assert property (startReq && !busy && clkEn &&
    memType == 2'h0 |=> !selN && eepromSelect_n == $past(startFlash))
    else $error("wrong select after start");
  chk_type_release: assert property ((memType != 2'h0)[*3] |->
    flashSelectShared_oe_n && eepromSelect_n && !spiPathActive)
    else $error("spi path active for two-wire code");
  chk_byte_bits: assert property (rxValid |->
    rises[2:0] == 3'h0 && rises != 8'h00)
    else $error("byte not eight clocks");
  chk_whole_bytes: assert property ($rose(selN) |-> rises[2:0] == 3'h0)
    else $error("select dropped mid byte");
  chk_reset_state: assert property ($fell(rst) |->
    busy && !sck && selN && flashSelectShared_oe_n)
    else $error("bad state after reset");
  cover property (startReq && !busy && !startFlash);
  cover property (startReq && !busy && startFlash);
  cover property (rxValid && !selN);
endmodule

bind snm_spi_master snm_spi_master_properties #(
  .ADDR_BYTES(ADDR_BYTES),
  .RESYNC_BITS(RESYNC_BITS)
) chk (
  .clk, .rst, .clkEn, .memType, .startReq, .startFlash, .rxValid, .busy,
  .sck, .mosi, .eepromSelect_n, .flashSelectShared_n,
  .flashSelectShared_oe_n, .spiPathActive
);

// ===== dv/snm_mem_model.sv
`timescale 1ns/10ps
// ------
// serial memory slave
// ------
// answers 8'ha5 first, then echoes the byte before
module snm_mem_model
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  output logic [7:0] lastByte,
  output int byteCount
);
  logic [7:0] shIn = 8'h00;
  logic [7:0] shOut = 8'ha5;
  int bitCnt = 0;
  initial miso = 1'b0;
  initial lastByte = 8'h00;
  initial byteCount = 0;
  always @(negedge sel_n)
  begin
    bitCnt = 0;
    shOut = 8'ha5;
    miso = shOut[7];
  end
  always @(posedge sck)
  begin
    if (!sel_n)
    begin
      shIn = {shIn[6:0], mosi};
      bitCnt = bitCnt + 1;
      if (bitCnt == 8)
      begin
        lastByte = shIn;
        byteCount = byteCount + 1;
        bitCnt = 0;
      end
    end
  end
  always @(negedge sck)
  begin
    if (!sel_n)
    begin
      shOut = (bitCnt == 0) ? lastByte : {shOut[6:0], 1'b0};
      miso = shOut[7];
    end
  end
  // partial bits dropped, line not held
  always @(posedge sel_n)
  begin
    bitCnt = 0;
    miso = ~miso;
  end
endmodule

// ===== dv/serial_nvm_spi_master_tb_top.sv
`timescale 1ns/10ps
module serial_nvm_spi_master_tb_top;
  localparam int RB = 8;
  logic clk = 0, rst = 1, clkEn = 0, startReq = 0, startFlash = 0;
  logic txLast = 0, miso, pinLvl, byteReq, rxValid, busy, sck, mosi;
  logic eeSel_n, flSel_n, flOe_n, spa;
  logic [1:0] memType = 2'h0;
  logic [7:0] txByte = 8'h00, rxByte, lastByte;
  int errors = 0, checks = 0, nb;
  // shared select has a pull-up
  assign pinLvl = flOe_n ? 1'b1 : flSel_n;
  snm_spi_master #(.RESYNC_BITS(RB)) uut (
    .clk, .rst, .clkEn, .memType, .startReq, .startFlash, .txByte,
    .txLast, .miso, .flashSelectShared_in(pinLvl), .byteReq, .rxByte,
    .rxValid, .busy, .sck, .mosi, .eepromSelect_n(eeSel_n),
    .flashSelectShared_n(flSel_n), .flashSelectShared_oe_n(flOe_n),
    .spiPathActive(spa));
  snm_mem_model mem (.sck, .mosi, .sel_n(eeSel_n & pinLvl), .miso,
    .lastByte, .byteCount(nb));
  initial forever #25 clk = ~clk;
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic give_verdict;
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset;
    int r;
    logic pv;
    r = 0;
    pv = 1'b0;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    cmp1(sck, 1'b0);
    cmp1(eeSel_n & pinLvl & flOe_n & busy, 1'b1);
    rst = 1'b0;
    clkEn = 1'b1;
    for (int i = 0; i < 300 && busy !== 1'b0; i++)
    begin
      @(negedge clk);
      if (sck && !pv)
        r++;
      if (!(eeSel_n & pinLvl))
        r += 100;
      pv = sck;
    end
    cmp8(8'(r), 8'(RB));
    cmp1(busy, 1'b0);
    cmp1(spa, 1'b1);
  endtask
  task automatic start(input logic fl, input logic [7:0] b0, input logic l);
    @(negedge clk);
    startFlash = fl;
    txByte = b0;
    txLast = l;
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
  endtask
  task automatic do_frame(input logic fl, input logic [7:0] b [4],
    input int n);
    int k, got, n0;
    k = 0;
    got = 0;
    n0 = nb;
    start(fl, b[0], n == 1);
    for (int i = 0; i < 80 * n && got < n; i++)
    begin
      if (k < n - 1 && (k == 0 || byteReq === 1'b1))
      begin
        k++;
        txByte = b[k];
        txLast = (k == n - 1);
      end
      @(negedge clk);
      if (rxValid === 1'b1)
      begin
        cmp8(lastByte, b[got]);
        cmp8(rxByte, got == 0 ? 8'ha5 : b[got - 1]);
        cmp1(fl ? eeSel_n : pinLvl, 1'b1);
        cmp1(fl ? pinLvl : eeSel_n, 1'b0);
        got++;
      end
    end
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(negedge clk);
    cmp8(8'(nb - n0), 8'(n));
    cmp1(eeSel_n & pinLvl & ~sck, 1'b1);
  endtask
  task automatic do_refuse;
    int n0;
    n0 = nb;
    for (int t = 1; t < 3; t++)
    begin
      @(negedge clk);
      memType = 2'(t);
      startReq = 1'b1;
      repeat (20) @(negedge clk);
      cmp1(flOe_n & eeSel_n & ~sck, 1'b1);
      cmp1(spa, 1'b0);
    end
    memType = 2'h0;
    startReq = 1'b0;
    cmp8(8'(nb - n0), 8'h00);
  endtask
  task automatic do_freeze;
    int n0, r;
    n0 = nb;
    r = 0;
    start(1'b0, 8'h3c, 1'b1);
    clkEn = 1'b0;
    repeat (20)
    begin
      @(negedge clk);
      if (sck !== 1'b0 || eeSel_n !== 1'b0)
        r++;
    end
    clkEn = 1'b1;
    cmp8(8'(r), 8'h00);
    for (int i = 0; i < 120 && busy !== 1'b0; i++)
      @(negedge clk);
    cmp8(lastByte, 8'h3c);
    cmp8(8'(nb - n0), 8'h01);
  endtask
  task automatic do_abort;
    int n0;
    n0 = nb;
    start(1'b0, 8'h02, 1'b0);
    repeat (30) @(negedge clk);
    do_reset();
    cmp8(8'(nb - n0), 8'h00);
  endtask
  initial
  begin
    do_reset();
    do_frame(1'b0, '{8'h02, 8'h01, 8'hff, 8'h5a}, 4);
    do_frame(1'b1, '{8'h0b, 8'h80, 8'h7e, 8'h00}, 3);
    do_frame(1'b1, '{8'h96, 8'h00, 8'h00, 8'h00}, 1);
    do_freeze();
    do_refuse();
    do_abort();
    do_frame(1'b0, '{8'h02, 8'h01, 8'hff, 8'h5a}, 4);
    give_verdict();
  end
  initial
  begin
    #(20000 * 50);
    errors++;
    give_verdict();
  end
endmodule
